// ==== design/vwm_pkg.sv ====
// package: indirect select codes, register field layout and reset values
package vwm_pkg;
  localparam logic [5:0] SEL_RANGE_ENABLE = 6'h05;
  localparam logic [5:0] SEL_DIAG = 6'h06;
  localparam logic [5:0] SEL_CAPTURE = 6'h07;
  localparam logic [5:0] SEL_WINDOW_BASE = 6'h20;
  localparam int NUM_WINDOWS = 32;
  // indirect access port layout
  localparam int PORT_SEL_LSB = 0;
  localparam int PORT_WRITE_BIT = 7;
  localparam int PORT_DATA_LSB = 14;
  localparam int PORT_DATA_W = 18;
  // range enable fields
  localparam int EXT_ENABLE_BIT = 26;
  localparam int STD_ENABLE_BIT = 25;
  localparam logic [31:0] RANGE_ENABLE_RESET = 32'h0000_0000;
  // diagnostic fields
  localparam int FORCE_DMA_READ_BIT = 17;
  localparam logic [31:0] DIAG_RESET = 32'h0000_0000;
  localparam logic [31:0] CAPTURE_RESET = 32'h0000_0000;
  // outbound window fields
  localparam int OFFSET_LSB = 20;
  localparam int ALEN_LSB = 18;
  localparam int DLEN_LSB = 16;
  localparam logic [15:0] WINDOW_RESET = 16'h0000;
  // error summary timeout status bit
  localparam int ERR_TIMEOUT_BIT = 23;
  // config reinit and bus error node reset bits
  localparam int CFG_REINIT_BIT = 22;
  localparam int BERR_NODE_RESET_BIT = 30;
  // address length codes
  localparam logic [1:0] ALEN_EXTENDED = 2'h0;
  localparam logic [1:0] ALEN_INVALID = 2'h1;
  localparam logic [1:0] ALEN_SHORT = 2'h2;
  localparam logic [1:0] ALEN_STANDARD = 2'h3;
  // data length codes
  localparam logic [1:0] DLEN_INVALID = 2'h0;
  localparam logic [1:0] DLEN_BYTE = 2'h1;
  localparam logic [1:0] DLEN_WORD = 2'h2;
  localparam logic [1:0] DLEN_LONG = 2'h3;
  // inbound address space kinds
  typedef enum logic [1:0] {
    VWM_SPACE_SHORT,
    VWM_SPACE_STANDARD,
    VWM_SPACE_EXTENDED,
    VWM_SPACE_NONE
  } vwm_space_e;
endpackage

// ==== design/vwm_inbound_filter.sv ====
// inbound vme decode: range enable check for vme-originated cycles
`timescale 1ns/100ps
module vwm_inbound_filter (
  // enables
  input wire logic ext_enable,
  input wire logic std_enable,
  // inbound cycle
  input wire logic [31:0] addr,
  input wire vwm_pkg::vwm_space_e space,
  input wire logic am_valid,
  // decision
  output logic accept
);
  // short space never claimed; unknown space never claimed
  always_comb begin
    accept = 1'b0;
    if (am_valid) begin
      case (space)
        vwm_pkg::VWM_SPACE_EXTENDED: accept = ext_enable && (addr[31:29] == 3'h0);
        vwm_pkg::VWM_SPACE_STANDARD: accept = std_enable && !addr[23];
        vwm_pkg::VWM_SPACE_SHORT: accept = 1'b0;
        default: accept = 1'b0;
      endcase
    end
  end
endmodule

// ==== design/vwm_window_map_regs.sv ====
// indirect mapping registers, inbound filter and outbound translation
// Function
// - extended enable accepts A31..A29 zero
// - extended enable clear refuses extended cycles
// - standard enable bit 25, accepts A23 zero
// - standard enable clear refuses standard cycles
// - range enable only via select 05
// - diagnostic register via select 06
// - force dma read bit self clears
// - capture data each cycle, freeze on timeout
// - unfreeze when timeout status cleared
// - capture register read-only, reset zero, select 07
// - 32 outbound windows at selects 20..3f
// - vme address is offset over low 20
// - address length field picks address space
// - never respond to short address cycles
// - read size from data length field
// - write size from internal bus mask
// - window bits 15:0 reserved read-only
// - bus error bit 30 write resets node
// - config bit 22 reinitialises vme machines
// - range enables ignore cpu outbound cycles
// - write in one access, read select first
// - reset returns every register to default
`timescale 1ns/100ps
module vwm_window_map_regs #(
  parameter int NUM_WIN = vwm_pkg::NUM_WINDOWS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // indirect access port (host side)
  input wire logic port_wr,
  input wire logic [31:0] port_wdata,
  input wire logic port_rd,
  output logic [31:0] port_rdata,
  // adapter-level init writes
  input wire logic berr_reg_wr,
  input wire logic [31:0] berr_reg_wdata,
  input wire logic cfg_reg_wr,
  input wire logic [31:0] cfg_reg_wdata,
  output logic node_reset,
  output logic vme_reinit,
  // error summary and timeout
  input wire logic [31:0] err_summary,
  input wire logic xfer_timeout,
  // vme data bus sample
  input wire logic [31:0] vme_data,
  // inbound vme cycle
  input wire logic in_valid,
  input wire logic [31:0] in_addr,
  input wire vwm_pkg::vwm_space_e in_space,
  input wire logic in_am_valid,
  output logic in_accept,
  output logic in_ignored,
  // outbound cpu cycle
  input wire logic out_valid,
  input wire logic out_write,
  input wire logic [4:0] out_win,
  input wire logic [19:0] out_addr,
  input wire logic [3:0] out_mask,
  output logic out_issue,
  output logic out_error,
  output logic [31:0] out_vme_addr,
  output logic [1:0] out_alen,
  output logic [2:0] out_size,
  // diagnostic strobe
  output logic force_dma_read
);
  ////////////////////////////////////////////////////////////////////
  logic [5:0] sel;
  logic sel_write;
  logic [31:0] range_enable;
  logic [31:0] diag_control;
  logic [31:0] capture;
  logic frozen;
  logic [15:0] win_hi [NUM_WIN];
  logic [17:0] wdata;
  logic write_hit;
  logic [31:0] sel_data;
  logic filt_accept;

  // written data rides in the top 18 bits of the port word
  assign wdata = port_wdata[vwm_pkg::PORT_DATA_LSB +: vwm_pkg::PORT_DATA_W];
  assign write_hit = port_wr && port_wdata[vwm_pkg::PORT_WRITE_BIT];

  function automatic logic is_window(input logic [5:0] s);
    is_window = (s >= vwm_pkg::SEL_WINDOW_BASE);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // select latch: every port write updates the select and write flag
  always_ff @(posedge clk) begin
    if (rst) begin
      sel <= 6'h00;
      sel_write <= 1'b0;
    end else if (port_wr) begin
      sel <= port_wdata[vwm_pkg::PORT_SEL_LSB +: 6];
      sel_write <= port_wdata[vwm_pkg::PORT_WRITE_BIT];
    end
  end

  // range enable: only two bits are live, the rest must be zero
  always_ff @(posedge clk) begin
    if (rst) begin
      range_enable <= vwm_pkg::RANGE_ENABLE_RESET;
    end else if (write_hit && port_wdata[5:0] == vwm_pkg::SEL_RANGE_ENABLE) begin
      range_enable <= {wdata, 14'h0000};
    end
  end

  // diagnostic register; force dma read drops the cycle after set
  always_ff @(posedge clk) begin
    if (rst) begin
      diag_control <= vwm_pkg::DIAG_RESET;
    end else if (write_hit && port_wdata[5:0] == vwm_pkg::SEL_DIAG) begin
      diag_control <= {wdata, 14'h0000};
    end else begin
      diag_control[vwm_pkg::FORCE_DMA_READ_BIT] <= 1'b0;
    end
  end
  assign force_dma_read = diag_control[vwm_pkg::FORCE_DMA_READ_BIT];

  // timeout capture: freeze on timeout, hold until status bit clears
  always_ff @(posedge clk) begin
    if (rst) begin
      frozen <= 1'b0;
      capture <= vwm_pkg::CAPTURE_RESET;
    end else begin
      // a timeout in the clearing cycle keeps the lock
      if (xfer_timeout) begin
        frozen <= 1'b1;
      end else if (!err_summary[vwm_pkg::ERR_TIMEOUT_BIT]) begin
        frozen <= 1'b0;
      end
      if (!frozen && !xfer_timeout) begin
        capture <= vme_data;
      end
    end
  end

  // outbound window table; low 16 bits are not storage
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_WIN; i++) begin
        win_hi[i] <= vwm_pkg::WINDOW_RESET;
      end
    end else if (write_hit && is_window(port_wdata[5:0])) begin
      win_hi[port_wdata[4:0]] <= wdata[17:2];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read mux; unknown selects read zero
  always_comb begin
    sel_data = 32'h0000_0000;
    if (sel == vwm_pkg::SEL_RANGE_ENABLE) begin
      sel_data = range_enable;
    end else if (sel == vwm_pkg::SEL_DIAG) begin
      sel_data = diag_control;
    end else if (sel == vwm_pkg::SEL_CAPTURE) begin
      sel_data = capture;
    end else if (is_window(sel)) begin
      sel_data = {win_hi[sel[4:0]], 16'h0000};
    end
  end

  // read data registered; with write flag set low bits show the port
  always_ff @(posedge clk) begin
    if (rst) begin
      port_rdata <= 32'h0000_0000;
    end else if (port_rd) begin
      if (sel_write) begin
        port_rdata <= {sel_data[31:14], 6'h00, sel_write, 1'b0, sel};
      end else begin
        port_rdata <= sel_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // init strobes: one-cycle pulses on the qualifying writes
  always_ff @(posedge clk) begin
    if (rst) begin
      node_reset <= 1'b0;
      vme_reinit <= 1'b0;
    end else begin
      node_reset <= berr_reg_wr && berr_reg_wdata[vwm_pkg::BERR_NODE_RESET_BIT];
      vme_reinit <= cfg_reg_wr && cfg_reg_wdata[vwm_pkg::CFG_REINIT_BIT];
    end
  end
  // system power-up emulation is driven from outside; rst covers it

  ////////////////////////////////////////////////////////////////////
  // inbound: enables reach only the vme-originated path
  vwm_inbound_filter u_filter (
    .ext_enable(range_enable[vwm_pkg::EXT_ENABLE_BIT]),
    .std_enable(range_enable[vwm_pkg::STD_ENABLE_BIT]),
    .addr(in_addr),
    .space(in_space),
    .am_valid(in_am_valid),
    .accept(filt_accept)
  );

  // refused cycles are only flagged, no ack and no bus error
  always_ff @(posedge clk) begin
    if (rst) begin
      in_accept <= 1'b0;
      in_ignored <= 1'b0;
    end else begin
      in_accept <= in_valid && filt_accept;
      in_ignored <= in_valid && !filt_accept;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outbound translation; range enables play no part here
  logic [15:0] w_sel;
  logic [1:0] w_alen;
  logic [1:0] w_dlen;
  logic bad_len;
  logic [2:0] next_size;
  assign w_sel = win_hi[out_win];
  assign w_alen = w_sel[vwm_pkg::ALEN_LSB - 16 +: 2];
  assign w_dlen = w_sel[vwm_pkg::DLEN_LSB - 16 +: 2];

  function automatic logic [2:0] mask_size(input logic [3:0] m);
    mask_size = 3'(m[0]) + 3'(m[1]) + 3'(m[2]) + 3'(m[3]);
  endfunction

  // size: reads from length field, writes from the byte mask
  always_comb begin
    next_size = 3'h0;
    bad_len = (w_alen == vwm_pkg::ALEN_INVALID);
    if (out_write) begin
      next_size = mask_size(out_mask);
      bad_len = bad_len || (out_mask == 4'h0);
    end else begin
      case (w_dlen)
        vwm_pkg::DLEN_BYTE: next_size = 3'h1;
        vwm_pkg::DLEN_WORD: next_size = 3'h2;
        vwm_pkg::DLEN_LONG: next_size = 3'h4;
        default: bad_len = 1'b1;
      endcase
    end
  end

  // registered outbound request toward the vme master engine
  always_ff @(posedge clk) begin
    if (rst) begin
      out_issue <= 1'b0;
      out_error <= 1'b0;
      out_vme_addr <= 32'h0000_0000;
      out_alen <= vwm_pkg::ALEN_EXTENDED;
      out_size <= 3'h0;
    end else begin
      out_issue <= out_valid && !bad_len;
      out_error <= out_valid && bad_len;
      if (out_valid) begin
        out_vme_addr <= {w_sel[15:4], out_addr};
        out_alen <= w_alen;
        out_size <= next_size;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // strobe self clear and capture lock
  a_dma_selfclr: assert property (@(posedge clk) disable iff (rst)
    force_dma_read |=> !force_dma_read) else $error("force dma read held");
  a_cap_frozen: assert property (@(posedge clk) disable iff (rst)
    (frozen && err_summary[vwm_pkg::ERR_TIMEOUT_BIT]) |=> $stable(capture))
    else $error("capture moved while frozen");
  a_cap_follow: assert property (@(posedge clk) disable iff (rst)
    (!frozen && !xfer_timeout) |=> capture == $past(vme_data))
    else $error("capture not following data");
  a_unfreeze: assert property (@(posedge clk) disable iff (rst)
    (!xfer_timeout && !err_summary[vwm_pkg::ERR_TIMEOUT_BIT]) |=> !frozen)
    else $error("lock not released");
  // reset values; capture moves on at once, so only here is its zero seen
  a_cap_reset: assert property (@(posedge clk)
    rst |=> (capture == vwm_pkg::CAPTURE_RESET))
    else $error("capture not cleared by reset");
  a_reg_reset: assert property (@(posedge clk)
    rst |=> (range_enable == vwm_pkg::RANGE_ENABLE_RESET
             && diag_control == vwm_pkg::DIAG_RESET && sel == 6'h00))
    else $error("register not cleared by reset");
  // inbound decisions
  a_ext_accept: assert property (@(posedge clk) disable iff (rst)
    (in_valid && in_am_valid && in_space == vwm_pkg::VWM_SPACE_EXTENDED
     && range_enable[vwm_pkg::EXT_ENABLE_BIT] && in_addr[31:29] == 3'h0) |=> in_accept)
    else $error("extended cycle not accepted");
  a_ext_refuse: assert property (@(posedge clk) disable iff (rst)
    (in_valid && in_space == vwm_pkg::VWM_SPACE_EXTENDED
     && !range_enable[vwm_pkg::EXT_ENABLE_BIT]) |=> !in_accept)
    else $error("extended accepted while off");
  a_std_accept: assert property (@(posedge clk) disable iff (rst)
    (in_valid && in_am_valid && in_space == vwm_pkg::VWM_SPACE_STANDARD
     && range_enable[vwm_pkg::STD_ENABLE_BIT] && !in_addr[23]) |=> in_accept)
    else $error("standard cycle not accepted");
  a_std_refuse: assert property (@(posedge clk) disable iff (rst)
    (in_valid && in_space == vwm_pkg::VWM_SPACE_STANDARD
     && !range_enable[vwm_pkg::STD_ENABLE_BIT]) |=> !in_accept)
    else $error("standard accepted while off");
  a_short_never: assert property (@(posedge clk) disable iff (rst)
    (in_valid && in_space == vwm_pkg::VWM_SPACE_SHORT) |=> (in_ignored && !in_accept))
    else $error("short cycle claimed");
  a_am_refuse: assert property (@(posedge clk) disable iff (rst)
    (in_valid && !in_am_valid) |=> (in_ignored && !in_accept))
    else $error("bad modifier cycle claimed");
  // register writes and read port
  a_enable_write: assert property (@(posedge clk) disable iff (rst)
    (write_hit && port_wdata[5:0] == vwm_pkg::SEL_RANGE_ENABLE)
    |=> (range_enable == {$past(wdata), 14'h0000}))
    else $error("range enable write lost");
  a_diag_write: assert property (@(posedge clk) disable iff (rst)
    (write_hit && port_wdata[5:0] == vwm_pkg::SEL_DIAG)
    |=> (diag_control[31:18] == $past(wdata[17:4])))
    else $error("diagnostic write lost");
  a_win_low: assert property (@(posedge clk) disable iff (rst)
    (port_rd && !sel_write && is_window(sel)) |=> (port_rdata[15:0] == 16'h0000))
    else $error("window low bits not zero");
  a_port_echo: assert property (@(posedge clk) disable iff (rst)
    (port_rd && sel_write) |=> (port_rdata[7:0] == {2'b10, $past(sel)}))
    else $error("port echo wrong");
  // outbound translation
  a_out_addr: assert property (@(posedge clk) disable iff (rst)
    out_valid |=> out_vme_addr[19:0] == $past(out_addr))
    else $error("low address not passed");
  a_offset_pass: assert property (@(posedge clk) disable iff (rst)
    out_valid |=> (out_vme_addr[31:20] == $past(w_sel[15:4])))
    else $error("offset not placed");
  a_alen_pass: assert property (@(posedge clk) disable iff (rst)
    (out_valid && !bad_len) |=> (out_alen == $past(w_alen)))
    else $error("address length not passed");
  a_out_err: assert property (@(posedge clk) disable iff (rst)
    (out_valid && w_alen == vwm_pkg::ALEN_INVALID) |=> (out_error && !out_issue))
    else $error("invalid length issued");
  a_read_size: assert property (@(posedge clk) disable iff (rst)
    (out_valid && !out_write && w_dlen == vwm_pkg::DLEN_LONG
     && w_alen != vwm_pkg::ALEN_INVALID) |=> (out_issue && out_size == 3'h4))
    else $error("read size wrong");
  a_write_size: assert property (@(posedge clk) disable iff (rst)
    (out_valid && out_write && out_mask == 4'hf
     && w_alen != vwm_pkg::ALEN_INVALID) |=> (out_issue && out_size == 3'h4))
    else $error("write size wrong");
  // init strobes
  a_node_rst: assert property (@(posedge clk) disable iff (rst)
    (berr_reg_wr && berr_reg_wdata[vwm_pkg::BERR_NODE_RESET_BIT]) |=> node_reset)
    else $error("node reset missing");
  a_reinit_pulse: assert property (@(posedge clk) disable iff (rst)
    (cfg_reg_wr && cfg_reg_wdata[vwm_pkg::CFG_REINIT_BIT]) |=> vme_reinit)
    else $error("reinit pulse missing");
endmodule

// ==== verification/vwm_vme_far.sv ====
// far-side model: vme data lines and transfer timeout source
`timescale 1ns/100ps
module vwm_vme_far (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request from the bench
  input wire logic tmo_req,
  // vme side
  output logic [31:0] vme_data,
  output logic xfer_timeout
);
  // data lines change every cycle, so a stale capture cannot match by luck
  always_ff @(posedge clk) begin
    if (rst) begin
      vme_data <= 32'h5a5a_0001;
    end else begin
      vme_data <= {vme_data[30:0], vme_data[31] ^ vme_data[21]} + 32'h1;
    end
  end
  // one timeout strobe per request, none during reset
  always_ff @(posedge clk) begin
    xfer_timeout <= tmo_req & ~rst;
  end
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the indirect mapping registers
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic port_wr = 1'b0, port_rd = 1'b0, berr_reg_wr = 1'b0, cfg_reg_wr = 1'b0;
  logic [31:0] port_wdata = 32'h0, berr_reg_wdata = 32'h0, cfg_reg_wdata = 32'h0;
  logic [31:0] err_summary = 32'h0, in_addr = 32'h0, port_rdata, vme_data, out_vme_addr;
  logic in_valid = 1'b0, in_am_valid = 1'b0, out_valid = 1'b0, out_write = 1'b0;
  logic tmo_req = 1'b0, xfer_timeout, node_reset, vme_reinit, force_dma_read;
  logic in_accept, in_ignored, out_issue, out_error;
  vwm_pkg::vwm_space_e in_space = vwm_pkg::VWM_SPACE_NONE;
  logic [4:0] out_win = 5'h0;
  logic [19:0] out_addr = 20'h0;
  logic [3:0] out_mask = 4'h0;
  logic [1:0] out_alen;
  logic [2:0] out_size;
  int err_count = 0;
  int tests_run = 0;
  logic [31:0] v, a, frozen, cap_exp;
  logic [17:0] d;
  logic [3:0] e;
  logic [5:0] sels [6] = '{6'h05, 6'h06, 6'h07, 6'h20, 6'h3f, 6'h03};
  int n;

  vwm_window_map_regs uut (.clk(clk), .rst(rst), .port_wr(port_wr), .port_wdata(port_wdata),
    .port_rd(port_rd), .port_rdata(port_rdata), .berr_reg_wr(berr_reg_wr),
    .berr_reg_wdata(berr_reg_wdata), .cfg_reg_wr(cfg_reg_wr), .cfg_reg_wdata(cfg_reg_wdata),
    .node_reset(node_reset), .vme_reinit(vme_reinit), .err_summary(err_summary),
    .xfer_timeout(xfer_timeout), .vme_data(vme_data), .in_valid(in_valid), .in_addr(in_addr),
    .in_space(in_space), .in_am_valid(in_am_valid), .in_accept(in_accept),
    .in_ignored(in_ignored), .out_valid(out_valid), .out_write(out_write), .out_win(out_win),
    .out_addr(out_addr), .out_mask(out_mask), .out_issue(out_issue), .out_error(out_error),
    .out_vme_addr(out_vme_addr), .out_alen(out_alen), .out_size(out_size),
    .force_dma_read(force_dma_read));
  vwm_vme_far far (.clk(clk), .rst(rst), .tmo_req(tmo_req), .vme_data(vme_data),
    .xfer_timeout(xfer_timeout));

  // 100 MHz clock
  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [5:0] sel, input logic [17:0] dat, input logic fl);
    @(posedge clk);
    port_wr <= 1'b1;
    port_wdata <= {dat, 6'h0, fl, 1'b0, sel};
    @(posedge clk);
    port_wr <= 1'b0;
  endtask
  // answer lands on the same edge that takes the read strobe; capture then
  // holds the data lines as they stood one edge earlier, before the previous edge's updates
  task rd_port(output logic [31:0] r);
    cap_exp = vme_data;
    port_rd <= 1'b1;
    @(posedge clk);
    port_rd <= 1'b0;
    #1 r = port_rdata;
  endtask
  task rd(input logic [5:0] sel, output logic [31:0] r);
    wr(sel, 18'h0, 1'b0);
    rd_port(r);
  endtask
  task side_wr(input int which, input logic [31:0] dat);
    @(posedge clk);
    if (which == 1) begin
      berr_reg_wr <= 1'b1;
      berr_reg_wdata <= dat;
    end else begin
      cfg_reg_wr <= 1'b1;
      cfg_reg_wdata <= dat;
    end
    @(posedge clk);
    berr_reg_wr <= 1'b0;
    cfg_reg_wr <= 1'b0;
  endtask
  // counts high cycles of a strobe, so a stuck or doubled pulse shows
  task pulse_count(input int which, output int cnt);
    cnt = 0;
    repeat (4) begin
      #1;
      cnt += (which == 0) ? int'(force_dma_read) : (which == 1) ? int'(node_reset)
        : int'(vme_reinit);
      @(posedge clk);
    end
  endtask
  task tend(input string name);
    $display("test %s done, checks %0d", name, tests_run);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function logic exp_in(input logic [1:0] en, input vwm_pkg::vwm_space_e sp, input logic am,
    input logic [31:0] ad);
    return am && ((sp == vwm_pkg::VWM_SPACE_EXTENDED && en[1] && ad[31:29] == 3'h0)
      || (sp == vwm_pkg::VWM_SPACE_STANDARD && en[0] && ad[23] == 1'b0));
  endfunction
  // {error, size in bytes} from stored window word, direction and mask
  function logic [3:0] exp_out(input logic [17:0] w, input logic wrt, input logic [3:0] m);
    logic [2:0] s;
    logic er;
    s = wrt ? 3'($countones(m)) : (w[3:2] == 2'h3 ? 3'h4 : {1'b0, w[3:2]});
    er = w[5:4] == vwm_pkg::ALEN_INVALID || (wrt ? m == 4'h0 : w[3:2] == vwm_pkg::DLEN_INVALID);
    return {er, s};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'hd410));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (sels[i]) begin
      rd(sels[i], v);
      // capture already tracks the data lines once reset is gone
      check(v, (sels[i] == vwm_pkg::SEL_CAPTURE) ? cap_exp : 32'h0);
    end
    tend("reset");
    d = 18'h01800;
    wr(vwm_pkg::SEL_RANGE_ENABLE, d, 1'b1);
    rd_port(v);
    check(v, {d, 6'h0, 1'b1, 1'b0, 6'h05});
    wr(vwm_pkg::SEL_RANGE_ENABLE, 18'h3ffff, 1'b0);
    rd_port(v);
    check(v, {d, 14'h0});
    for (int k = 0; k < 16; k++) begin
      n = (k == 0) ? 0 : (k == 1) ? 31 : int'($urandom_range(31));
      d = 18'($urandom);
      wr(vwm_pkg::SEL_WINDOW_BASE + 6'(n), d, 1'b1);
      rd(vwm_pkg::SEL_WINDOW_BASE + 6'(n), v);
      check(v, {d[17:2], 16'h0});
    end
    tend("registers");
    for (int k = 0; k < 64; k++) begin
      if (k[3:0] == 4'h0) wr(vwm_pkg::SEL_RANGE_ENABLE, {5'h0, 2'(k >> 4), 11'h0}, 1'b1);
      a = $urandom;
      if (k[3]) begin
        a[31:29] = 3'h0;
        a[23] = 1'b0;
      end
      @(posedge clk);
      in_valid <= 1'b1;
      in_addr <= a;
      in_space <= vwm_pkg::vwm_space_e'(k[1:0]);
      in_am_valid <= k[2];
      @(posedge clk);
      in_valid <= 1'b0;
      #1 e[0] = exp_in(2'(k >> 4), vwm_pkg::vwm_space_e'(k[1:0]), k[2], a);
      check({in_accept, in_ignored}, {e[0], ~e[0]});
    end
    tend("inbound");
    for (int k = 0; k < 48; k++) begin
      n = int'($urandom_range(31));
      d = 18'($urandom);
      if (k < 16) d[5:2] = 4'(k);
      wr(vwm_pkg::SEL_WINDOW_BASE + 6'(n), d, 1'b1);
      a = $urandom;
      @(posedge clk);
      out_valid <= 1'b1;
      out_write <= a[31];
      out_win <= 5'(n);
      out_addr <= a[19:0];
      out_mask <= a[27:24];
      @(posedge clk);
      out_valid <= 1'b0;
      #1 e = exp_out(d, a[31], a[27:24]);
      check({out_error, out_issue}, {e[3], ~e[3]});
      if (!e[3]) begin
        check(out_vme_addr, {d[17:6], a[19:0]});
        check({out_alen, out_size}, {d[5:4], e[2:0]});
      end
    end
    tend("outbound");
    wr(vwm_pkg::SEL_DIAG, 18'h20008, 1'b1);
    pulse_count(0, n);
    check(n, 1);
    rd(vwm_pkg::SEL_DIAG, v);
    check(v[17], 1'b0);
    check(v, 32'h8000_0000);
    side_wr(1, 32'h4000_0000);
    pulse_count(1, n);
    check(n, 1);
    side_wr(1, 32'hbfff_ffff);
    pulse_count(1, n);
    check(n, 0);
    side_wr(2, 32'h0040_0000);
    pulse_count(2, n);
    check(n, 1);
    tend("strobes");
    // system-level reset in mid-run: registers fall back to defaults
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(vwm_pkg::SEL_RANGE_ENABLE, v);
    check(v, 32'h0);
    rd(vwm_pkg::SEL_WINDOW_BASE, v);
    check(v, 32'h0);
    tend("mid reset");
    @(posedge clk);
    tmo_req <= 1'b1;
    err_summary <= 32'h0080_0000;
    @(posedge clk);
    frozen = vme_data;
    tmo_req <= 1'b0;
    repeat (5) @(posedge clk);
    rd(vwm_pkg::SEL_CAPTURE, v);
    check(v, frozen);
    wr(vwm_pkg::SEL_CAPTURE, 18'h2aaaa, 1'b1);
    rd(vwm_pkg::SEL_CAPTURE, v);
    check(v, frozen);
    @(posedge clk);
    err_summary <= 32'h0;
    repeat (3) @(posedge clk);
    rd(vwm_pkg::SEL_CAPTURE, v);
    check(v, cap_exp);
    tend("capture");
    test_done();
  end
endmodule
